//--- gie_ops.sv
// Status word update and interrupt gating for the global interrupt enable operations
`timescale 1ns/1ns
module gie_ops
	import gie_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Instruction stream, one completed instruction per valid cycle
	input wire gie_instr_t instr,
	// Maskable interrupt request from the interrupt sources
	input wire logic irq_pending,
	// Status word and interrupt acceptance
	output logic [15:0] status_word,
	output logic global_irq_enable_flag,
	output logic oscillator_off_flag,
	output logic core_halt_flag,
	output logic irq_accept
);
	// One decoder shared by every op strobe
	function automatic logic op_is(input gie_instr_t word, input gie_op_t code);
		return word.valid && word.op == code;
	endfunction

	wire logic irq_disable_op = op_is(instr, GIE_OP_DISABLE);
	wire logic irq_enable_op = op_is(instr, GIE_OP_ENABLE);
	wire logic sw_write = op_is(instr, GIE_OP_WRITE);
	wire logic sw_idle = op_is(instr, GIE_OP_NONE) || !instr.valid;

	// Same path as a bit clear or bit set with the constant mask as source
	wire logic [15:0] bit_clear_op = status_word & GIE_DISABLE_MASK;
	wire logic [15:0] bit_set_op = status_word | GIE_ENABLE_MASK;

	wire logic [15:0] next_status_word = irq_disable_op ? bit_clear_op :
		irq_enable_op ? bit_set_op :
		sw_write ? instr.data : status_word;

	logic shadow;

	gie_shadow #(
		.SHADOW(GIE_SHADOW_CYCLES)
	) u_shadow (
		.clk(clk),
		.srst(srst),
		.arm(irq_enable_op),
		.instr_done(instr.valid),
		.active(shadow)
	);

	// Acceptance reads the written-back flag, so a disable op only masks from the
	// next instruction on; software covers that gap with a no-op.
	wire logic next_accept = irq_pending && status_word[GIE_BIT_GIE] && !shadow
		&& !irq_accept;

	always_ff @(posedge clk)
	begin
		if (srst)
			status_word <= GIE_SW_RESET;
		else
			status_word <= next_status_word;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			global_irq_enable_flag <= 1'b0;
			oscillator_off_flag <= 1'b0;
			core_halt_flag <= 1'b0;
			irq_accept <= 1'b0;
		end
		else
		begin
			global_irq_enable_flag <= next_status_word[GIE_BIT_GIE];
			oscillator_off_flag <= next_status_word[GIE_BIT_OSCILLATOR_OFF_FLAG];
			core_halt_flag <= next_status_word[GIE_BIT_CORE_HALT_FLAG];
			irq_accept <= next_accept;
		end
	end

	sequence s_disable;
		irq_disable_op;
	endsequence

	sequence s_enable;
		irq_enable_op;
	endsequence

	a_disable_clears: assert property (@(posedge clk) disable iff (srst)
		s_disable |=> status_word == ($past(status_word) & 16'hFFF7))
		else $error("disable op result wrong");

	a_disable_keeps_mode: assert property (@(posedge clk) disable iff (srst)
		s_disable |=> !status_word[GIE_BIT_GIE]
		&& $stable(status_word[GIE_BIT_OSCILLATOR_OFF_FLAG:GIE_BIT_CORE_HALT_FLAG]))
		else $error("disable op disturbed mode bits");

	a_enable_sets: assert property (@(posedge clk) disable iff (srst)
		s_enable |=> status_word == ($past(status_word) | 16'h0008))
		else $error("enable op result wrong");

	a_enable_keeps_mode: assert property (@(posedge clk) disable iff (srst)
		s_enable |=> status_word[GIE_BIT_GIE]
		&& $stable(status_word[GIE_BIT_OSCILLATOR_OFF_FLAG:GIE_BIT_CORE_HALT_FLAG]))
		else $error("enable op disturbed mode bits");

	a_arith_flags_kept: assert property (@(posedge clk) disable iff (srst)
		(irq_disable_op || irq_enable_op) |=> $stable(status_word[2:0])
		&& $stable(status_word[GIE_BIT_V]))
		else $error("condition flags changed");

	a_no_accept_masked: assert property (@(posedge clk) disable iff (srst)
		irq_accept |-> $past(status_word[GIE_BIT_GIE]) && $past(irq_pending))
		else $error("request accepted while masked");

	a_flag_mirror: assert property (@(posedge clk) disable iff (srst)
		global_irq_enable_flag == status_word[3])
		else $error("enable flag not on bit 3");

	// Open from an enable op until the next instruction completes; counted in
	// instructions, so a stalled core keeps the check open for as long as it stalls.
	logic after_enable;
	wire logic next_after_enable = irq_enable_op ? 1'b1 :
		instr.valid ? 1'b0 : after_enable;

	always_ff @(posedge clk)
	begin
		if (srst)
			after_enable <= 1'b0;
		else
			after_enable <= next_after_enable;
	end

	sequence s_wait_next;
		after_enable;
	endsequence

	sequence s_masked;
		!status_word[GIE_BIT_GIE];
	endsequence

	sequence s_open;
		irq_pending && status_word[GIE_BIT_GIE] && !shadow && !irq_accept;
	endsequence

	sequence s_write;
		sw_write;
	endsequence

	sequence s_idle;
		sw_idle;
	endsequence

	a_enable_shadow: assert property (@(posedge clk) disable iff (srst)
		s_wait_next |=> !irq_accept)
		else $error("request taken before next instruction");

	a_shadow_arms: assert property (@(posedge clk) disable iff (srst)
		s_enable |=> shadow)
		else $error("shadow not armed by enable op");

	a_shadow_holds: assert property (@(posedge clk) disable iff (srst)
		shadow && !instr.valid |=> shadow)
		else $error("shadow dropped with no instruction done");

	a_shadow_ends: assert property (@(posedge clk) disable iff (srst)
		s_wait_next ##0 (instr.valid && !irq_enable_op) |=> !shadow)
		else $error("shadow outlived the next instruction");

	a_masked_refuses: assert property (@(posedge clk) disable iff (srst)
		s_masked |=> !irq_accept)
		else $error("request accepted with enable flag clear");

	a_open_accepts: assert property (@(posedge clk) disable iff (srst)
		s_open |=> irq_accept)
		else $error("eligible request not accepted");

	a_disable_latency: assert property (@(posedge clk) disable iff (srst)
		s_disable |-> ##2 !irq_accept)
		else $error("request accepted after disable took effect");

	a_accept_single: assert property (@(posedge clk) disable iff (srst)
		irq_accept |=> !irq_accept)
		else $error("accept pulse longer than one cycle");

	a_no_request_idle: assert property (@(posedge clk) disable iff (srst)
		!irq_pending |=> !irq_accept)
		else $error("accept with no request pending");

	a_enable_flag_up: assert property (@(posedge clk) disable iff (srst)
		s_enable |=> global_irq_enable_flag)
		else $error("enable flag output not set");

	a_disable_flag_down: assert property (@(posedge clk) disable iff (srst)
		s_disable |=> !global_irq_enable_flag)
		else $error("enable flag output not cleared");

	a_mode_mirror: assert property (@(posedge clk) disable iff (srst)
		oscillator_off_flag == status_word[GIE_BIT_OSCILLATOR_OFF_FLAG]
		&& core_halt_flag == status_word[GIE_BIT_CORE_HALT_FLAG])
		else $error("mode flag outputs differ from status word");

	a_write_loads: assert property (@(posedge clk) disable iff (srst)
		s_write |=> status_word == $past(instr.data))
		else $error("status write not loaded");

	a_write_flag: assert property (@(posedge clk) disable iff (srst)
		s_write |=> global_irq_enable_flag == $past(instr.data[GIE_BIT_GIE]))
		else $error("written enable bit not on flag output");

	a_idle_keeps: assert property (@(posedge clk) disable iff (srst)
		s_idle |=> $stable(status_word))
		else $error("status word changed with no op");

	a_reset_state: assert property (@(posedge clk)
		srst |=> status_word == GIE_SW_RESET && !irq_accept && !global_irq_enable_flag)
		else $error("outputs not cleared by reset");
endmodule

//--- gie_pkg.sv
// Package with status word layout, operation codes and carriers for the interrupt enable ops
package gie_pkg;
	localparam int GIE_SW_W = 16;
	localparam int GIE_BIT_C = 0;
	localparam int GIE_BIT_Z = 1;
	localparam int GIE_BIT_N = 2;
	localparam int GIE_BIT_GIE = 3;
	localparam int GIE_BIT_CORE_HALT_FLAG = 4;
	localparam int GIE_BIT_OSCILLATOR_OFF_FLAG = 5;
	localparam int GIE_BIT_V = 8;
	localparam logic [15:0] GIE_ENABLE_MASK = 16'h0008;
	localparam logic [15:0] GIE_DISABLE_MASK = 16'hFFF7;
	localparam logic [15:0] GIE_SW_RESET = 16'h0000;
	localparam int GIE_SHADOW_CYCLES = 1;

	typedef enum logic [1:0]
	{
		GIE_OP_NONE = 2'b00,
		GIE_OP_DISABLE = 2'b01,
		GIE_OP_ENABLE = 2'b10,
		GIE_OP_WRITE = 2'b11
	} gie_op_t;

	typedef struct packed
	{
		logic valid;
		gie_op_t op;
		logic [15:0] data;
	} gie_instr_t;
endpackage

//--- gie_shadow.sv
// Small module that holds off interrupt acceptance for the instruction after an enable
`timescale 1ns/1ns
module gie_shadow
	import gie_pkg::*;
#(
	parameter int SHADOW = GIE_SHADOW_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic arm,
	input wire logic instr_done,
	// Status
	output logic active
);
	// Refused at elaboration: the down counter is only four bits wide
	if (SHADOW < 1 || SHADOW > 15)
	begin : g_bad_shadow
		$error("gie_shadow: SHADOW out of range");
	end

	logic [3:0] left;
	wire logic [3:0] next_left = arm ? 4'(SHADOW) :
		(instr_done && left != 4'h0) ? left - 4'h1 : left;

	always_ff @(posedge clk)
	begin
		if (srst)
			left <= 4'h0;
		else
			left <= next_left;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			active <= 1'b0;
		else
			active <= (next_left != 4'h0);
	end
endmodule

//--- gie_prog.sv
// Program model issuing one instruction per call
`timescale 1ns/1ns
module gie_prog
	import gie_pkg::*;
(
	// Clock and instruction stream
	input wire logic clk,
	output gie_instr_t instr
);
	initial instr = '0;
	task automatic issue(input gie_op_t op, input logic [15:0] d);
		@(negedge clk) instr = '{1'b1, op, d};
		@(negedge clk) instr = '0;
	endtask
endmodule

//--- gie_ops_tb_top.sv
// Bench for the interrupt enable operations
`timescale 1ns/1ns
module gie_ops_tb_top
	import gie_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic irq_pending = 1'b0;
	gie_instr_t instr;
	logic [15:0] sw;
	logic gie, osc, halt, acc;
	int n_errors = 0;
	int samples_checked = 0;
	int n_acc = 0;
	initial forever #10 clk = ~clk;
	gie_prog i_gie_prog (.clk(clk), .instr(instr));
	gie_ops i_gie_ops (.clk(clk), .srst(srst), .instr(instr), .irq_pending(irq_pending),
		.status_word(sw), .global_irq_enable_flag(gie), .oscillator_off_flag(osc),
		.core_halt_flag(halt), .irq_accept(acc));
	always @(posedge clk) if (acc === 1'b1) n_acc++;
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop();
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_disable();
		i_gie_prog.issue(GIE_OP_WRITE, 16'hFFFF);
		i_gie_prog.issue(GIE_OP_DISABLE, 16'h0000);
		chk("sw_dis", 16'hFFF7, sw);
		chk("flg_dis", 16'h0003, {13'h0, gie, osc, halt});
	endtask
	task automatic t_enable();
		i_gie_prog.issue(GIE_OP_WRITE, 16'h0137);
		i_gie_prog.issue(GIE_OP_ENABLE, 16'h0000);
		chk("sw_en", 16'h013F, sw);
		chk("flg_en", 16'h0007, {13'h0, gie, osc, halt});
	endtask
	// Request held high so only the shadow, then the cleared enable flag, stops an accept
	task automatic t_shadow();
		i_gie_prog.issue(GIE_OP_WRITE, 16'h0000);
		irq_pending = 1'b1;
		n_acc = 0;
		i_gie_prog.issue(GIE_OP_ENABLE, 16'h0000);
		repeat (3) @(negedge clk);
		chk("acc_shadow", 16'h0000, n_acc[15:0]);
		i_gie_prog.issue(GIE_OP_WRITE, 16'h0008);
		repeat (3) @(negedge clk);
		chk("acc_open", 16'h0001, {15'h0, n_acc > 0});
		i_gie_prog.issue(GIE_OP_DISABLE, 16'h0000);
		i_gie_prog.issue(GIE_OP_NONE, 16'h0000);
		n_acc = 0;
		repeat (4) @(negedge clk);
		chk("acc_masked", 16'h0000, n_acc[15:0]);
		irq_pending = 1'b0;
	endtask
	initial
	begin
		repeat (2) @(negedge clk);
		srst = 1'b0;
		chk("sw_rst", 16'h0000, sw);
		t_disable();
		t_enable();
		t_shadow();
		report_and_stop();
	end
	initial
	begin
		#100000;
		n_errors++;
		report_and_stop();
	end
endmodule
